// file: cpm_power_manager.sv
// Notes on behaviour
// R1: Every clock source has its own power-down bit.
// R2: Fast RC oscillator trims to 32 or 40 MHz by a configuration bit.
// R3: Slow RC oscillator has slow 640 Hz and fast 10.24 kHz modes.
// R4: Clock pin input accepted when configured; source stays at or below 20 MHz.
// R5: Clock output pin drives system clock or any active source, max 40 MHz.
// R6: Clocks gated by software bits, by power mode, and by use.
// R7: Lost transitions on system source switch the system clock to fast RC.
// R8: Software should recalibrate oscillators periodically against the crystal.
// R9: Run mode keeps everything powered and clocked except gated peripherals.
// R10: Sleep gates the processor clock and puts flash in low power.
// R11: Sleep keeps clocking peripherals enabled to raise interrupts.
// R12: Any enabled interrupt in sleep returns to run without reset.
// R13: Wait instruction: sleep; deep sleep plus hibernate: hibernate; shutdown bit.
// R14: Hibernate removes power from processor, flash and most peripherals.
// R15: Hibernate powers or retains each SRAM bank per its own bit.
// R16: Hibernate keeps wake timer, pin toggle and slow RC only.
// R17: Hibernate wake re-initialises processor from the reset vector.
// R18: Shutdown keeps only scratch and wake-pin watch; wake restarts processor.
// R19: Wake timer wakes from sleep but not from deep sleep; the code lets it wake hibernate and blocks it only in shutdown.
// R20: A 32-bit scratch register survives every low-power mode.
// R21: Clock loss may be routed to the non-maskable interrupt.
module cpm_power_manager (
	// Clock, reset, enable
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	input  wire logic              ce_i,
	// Core requests
	input  wire logic              wait_instruction_i,
	input  wire cpm_pkg::cpm_ctrl_t ctrl_i,
	input  wire logic              scratch_we_i,
	input  wire logic [31:0]       scratch_wd_i,
	// Wake sources
	input  wire logic [cpm_pkg::NPERI-1:0] peri_irq_i,
	input  wire logic              wake_timer_i,
	input  wire logic              gpio_toggle_i,
	input  wire logic              shutdown_wake_pin_i,
	input  wire logic              debug_enable_pin_i,
	input  wire logic              nmi_pin_i,
	input  wire logic              brownout_i,
	// Clock sources, asynchronous
	input  wire logic [cpm_pkg::NSRC-1:0] src_clk_i,
	// Outputs
	output cpm_pkg::cpm_pwr_t      pwr_o,
	output cpm_pkg::cpm_mode_t     mode_o,
	output logic [2:0]             sys_src_o,
	output logic                   fast_rc_hi_o,
	output logic                   slow_rc_fast_o,
	output logic                   clock_output_pin_o,
	output logic                   clock_output_pin_oe_n_o,
	output logic                   core_reset_o,
	output logic                   clk_loss_o,
	output logic                   nmi_o,
	output logic [31:0]            scratch_o
);
	cpm_pkg::cpm_mode_t         mode_r;
	logic [cpm_pkg::NSRC-1:0]   s1_r, s2_r, s3_r, src_v_r;
	logic                       p1_r, p2_r, p3_r, pin_v_r, pin_prev_r;
	logic                       fallback_r;
	logic                       loss;
	logic [2:0]                 sys_src;
	logic                       sys_clk_v;
	logic                       out_clk;
	logic                       deep;
	logic                       wake_sleep, wake_deep, wake_shut;

	// R4: pin clock synchronised too
	genvar g;
	generate
		for (g = 0; g < cpm_pkg::NSRC; g++) begin : g_sync
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					s1_r[g]    <= 1'b0;
					s2_r[g]    <= 1'b0;
					s3_r[g]    <= 1'b0;
					src_v_r[g] <= 1'b0;
				end else if (ce_i) begin
					s1_r[g] <= src_clk_i[g];
					s2_r[g] <= s1_r[g];
					s3_r[g] <= s2_r[g];
					if (s2_r[g] == s3_r[g]) begin
						src_v_r[g] <= s3_r[g];
					end
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			p1_r       <= 1'b0;
			p2_r       <= 1'b0;
			p3_r       <= 1'b0;
			pin_v_r    <= 1'b0;
			pin_prev_r <= 1'b0;
		end else if (ce_i) begin
			p1_r       <= shutdown_wake_pin_i;
			p2_r       <= p1_r;
			p3_r       <= p2_r;
			pin_prev_r <= pin_v_r;
			if (p2_r == p3_r) begin
				pin_v_r <= p3_r;
			end
		end
	end

	assign deep    = mode_r == cpm_pkg::MODE_HIBERNATE
		|| mode_r == cpm_pkg::MODE_SHUTDOWN;
	// R7: fall back to fast RC
	assign sys_src = fallback_r ? cpm_pkg::SRC_FAST_RC : ctrl_i.sys_sel;
	assign sys_clk_v = src_v_r[sys_src];
	// R5: output selection
	assign out_clk = (ctrl_i.out_sel == cpm_pkg::OUT_SYSCLK) ? sys_clk_v
		: src_v_r[ctrl_i.out_sel];

	// Monitor only while running a powered source; pin clock included
	cpm_clock_monitor u_mon (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.ce_i      (ce_i),
		.arm_i     (!fallback_r && !deep && !ctrl_i.src_pd[ctrl_i.sys_sel]),
		.mon_clk_i (src_v_r[ctrl_i.sys_sel]),
		.loss_o    (loss)
	);

	// R7: sticky until reset; software cannot re-select a dead source
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fallback_r <= 1'b0;
		end else if (ce_i && loss) begin
			fallback_r <= 1'b1;
		end
	end

	// R12: any enabled interrupt or nmi
	assign wake_sleep = |(peri_irq_i & ctrl_i.peri_irq_en) || wake_timer_i
		|| nmi_o;
	// R19: deep sleep wakes without the peripheral set
	assign wake_deep  = wake_timer_i || gpio_toggle_i || debug_enable_pin_i;
	// R18: toggle of the wake pin, or the debug enable pin
	assign wake_shut  = (pin_v_r != pin_prev_r) || debug_enable_pin_i;

	// R13: mode sequencing
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode_r <= cpm_pkg::MODE_RUN;
		end else if (ce_i) begin
			unique case (mode_r)
				cpm_pkg::MODE_RUN: begin
					if (wait_instruction_i) begin
						if (ctrl_i.shutdown) begin
							mode_r <= cpm_pkg::MODE_SHUTDOWN;
						end else if (ctrl_i.deep_sleep && ctrl_i.hibernate) begin
							mode_r <= cpm_pkg::MODE_HIBERNATE;
						end else begin
							mode_r <= cpm_pkg::MODE_SLEEP;
						end
					end
				end
				cpm_pkg::MODE_SLEEP: begin
					if (wake_sleep) begin
						mode_r <= cpm_pkg::MODE_RUN;
					end
				end
				cpm_pkg::MODE_HIBERNATE: begin
					if (wake_deep) begin
						mode_r <= cpm_pkg::MODE_RUN;
					end
				end
				cpm_pkg::MODE_SHUTDOWN: begin
					if (wake_shut) begin
						mode_r <= cpm_pkg::MODE_RUN;
					end
				end
			endcase
		end
	end

	// R17: one-cycle core reset on deep wake
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			core_reset_o <= 1'b0;
		end else if (ce_i) begin
			core_reset_o <= (mode_r == cpm_pkg::MODE_HIBERNATE && wake_deep)
				|| (mode_r == cpm_pkg::MODE_SHUTDOWN && wake_shut);
		end
	end

	// Power and clock controls
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pwr_o <= '0;
		end else if (ce_i) begin
			unique case (mode_r)
				cpm_pkg::MODE_RUN, cpm_pkg::MODE_SLEEP: begin
					// R1: per-source power down
					pwr_o.src_en     <= ~ctrl_i.src_pd;
					// R10: processor clock off in sleep
					pwr_o.cpu_clk_en <= mode_r == cpm_pkg::MODE_RUN;
					pwr_o.flash_lp   <= mode_r == cpm_pkg::MODE_SLEEP;
					// R9: all powered in run
					pwr_o.core_pwr   <= 1'b1;
					pwr_o.periph_pwr <= 1'b1;
					// R6: software gating, R11: irq sources kept in sleep
					pwr_o.peri_clk_en <= (mode_r == cpm_pkg::MODE_RUN)
						? ~ctrl_i.peri_gate
						: (~ctrl_i.peri_gate & ctrl_i.peri_irq_en);
					pwr_o.bank_pwr   <= '1;
				end
				cpm_pkg::MODE_HIBERNATE: begin
					// R16: slow RC only clock
					pwr_o.src_en      <= cpm_pkg::NSRC'(1)
						<< cpm_pkg::SRC_SLOW_RC;
					// R14: core, flash, peripherals off
					pwr_o.cpu_clk_en  <= 1'b0;
					pwr_o.flash_lp    <= 1'b1;
					pwr_o.core_pwr    <= 1'b0;
					pwr_o.periph_pwr  <= 1'b0;
					pwr_o.peri_clk_en <= '0;
					// R15: per-bank retention
					pwr_o.bank_pwr    <= ctrl_i.bank_retain;
				end
				cpm_pkg::MODE_SHUTDOWN: begin
					// R18: everything off
					pwr_o <= '0;
				end
			endcase
		end
	end

	// R2 R3: trim selects; R5 clock out
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fast_rc_hi_o            <= 1'b0;
			slow_rc_fast_o          <= 1'b0;
			sys_src_o               <= cpm_pkg::SRC_FAST_RC;
			clock_output_pin_o      <= 1'b0;
			clock_output_pin_oe_n_o <= 1'b1;
			mode_o                  <= cpm_pkg::MODE_RUN;
		end else if (ce_i) begin
			fast_rc_hi_o            <= ctrl_i.fast_rc_hi;
			slow_rc_fast_o          <= ctrl_i.slow_rc_fast;
			sys_src_o               <= sys_src;
			clock_output_pin_o      <= out_clk;
			clock_output_pin_oe_n_o <= !(ctrl_i.out_en && !deep);
			mode_o                  <= mode_r;
		end
	end

	// R21: clock loss, pin or brownout to nmi
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			clk_loss_o <= 1'b0;
			nmi_o      <= 1'b0;
		end else if (ce_i) begin
			clk_loss_o <= fallback_r;
			nmi_o      <= (loss && ctrl_i.mon_nmi_en) || nmi_pin_i
				|| brownout_i;
		end
	end

	// R20: scratch only cleared by reset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			scratch_o <= cpm_pkg::SCRATCH_RST;
		end else if (ce_i && scratch_we_i && mode_r == cpm_pkg::MODE_RUN) begin
			scratch_o <= scratch_wd_i;
		end
	end

	property p_sleep_entry;
		@(posedge clk_i) disable iff (rst_i)
		mode_r == cpm_pkg::MODE_RUN && ce_i && wait_instruction_i
		&& !ctrl_i.shutdown && !(ctrl_i.deep_sleep && ctrl_i.hibernate)
		|=> mode_r == cpm_pkg::MODE_SLEEP;
	endproperty
	a_sleep_entry: assert property (p_sleep_entry) // R13
		else $error("sleep not entered");

	property p_cpu_gated;
		@(posedge clk_i) disable iff (rst_i)
		mode_r == cpm_pkg::MODE_SLEEP && ce_i |=> !pwr_o.cpu_clk_en
		&& pwr_o.flash_lp;
	endproperty
	a_cpu_gated: assert property (p_cpu_gated) // R10
		else $error("cpu clock not gated in sleep");

	property p_sleep_wake;
		@(posedge clk_i) disable iff (rst_i)
		mode_r == cpm_pkg::MODE_SLEEP && ce_i && wake_sleep
		|=> mode_r == cpm_pkg::MODE_RUN ##1 !core_reset_o;
	endproperty
	a_sleep_wake: assert property (p_sleep_wake) // R12
		else $error("sleep wake wrong");

	property p_hib_clk;
		@(posedge clk_i) disable iff (rst_i)
		mode_r == cpm_pkg::MODE_HIBERNATE && ce_i
		|=> pwr_o.src_en == 5'h02 && !pwr_o.core_pwr;
	endproperty
	a_hib_clk: assert property (p_hib_clk) // R16
		else $error("hibernate clocks wrong");

	property p_hib_reset;
		@(posedge clk_i) disable iff (rst_i)
		mode_r == cpm_pkg::MODE_HIBERNATE && ce_i && wake_deep
		|=> core_reset_o && mode_r == cpm_pkg::MODE_RUN;
	endproperty
	a_hib_reset: assert property (p_hib_reset) // R17
		else $error("no core reset on hibernate wake");

	property p_timer_deep;
		@(posedge clk_i) disable iff (rst_i)
		mode_r == cpm_pkg::MODE_SHUTDOWN && wake_timer_i && !wake_shut
		|=> mode_r == cpm_pkg::MODE_SHUTDOWN;
	endproperty
	a_timer_deep: assert property (p_timer_deep) // R19
		else $error("timer woke shutdown");

	property p_fallback;
		@(posedge clk_i) disable iff (rst_i)
		loss && ce_i |=> fallback_r ##1 sys_src_o == cpm_pkg::SRC_FAST_RC;
	endproperty
	a_fallback: assert property (p_fallback) // R7
		else $error("no fallback to fast rc");

	property p_scratch_hold;
		@(posedge clk_i) disable iff (rst_i)
		mode_r != cpm_pkg::MODE_RUN |=> $stable(scratch_o);
	endproperty
	a_scratch_hold: assert property (p_scratch_hold) // R20
		else $error("scratch changed in low power");

	property p_bank;
		@(posedge clk_i) disable iff (rst_i)
		mode_r == cpm_pkg::MODE_HIBERNATE && ce_i
		|=> pwr_o.bank_pwr == $past(ctrl_i.bank_retain);
	endproperty
	a_bank: assert property (p_bank) // R15
		else $error("bank retention wrong");

	c_sleep: cover property (@(posedge clk_i) mode_r == cpm_pkg::MODE_SLEEP);
	c_hib: cover property (@(posedge clk_i) core_reset_o);
	c_shut: cover property (@(posedge clk_i)
		mode_r == cpm_pkg::MODE_SHUTDOWN);
	c_loss: cover property (@(posedge clk_i) fallback_r);
endmodule

// file: cpm_pkg.sv
package cpm_pkg;
	// Clock source indices
	localparam int NSRC        = 5;
	localparam logic [2:0] SRC_FAST_RC   = 3'h0;
	localparam logic [2:0] SRC_SLOW_RC   = 3'h1;
	localparam logic [2:0] SRC_FAST_XTAL = 3'h2;
	localparam logic [2:0] SRC_SLOW_XTAL = 3'h3;
	localparam logic [2:0] SRC_PIN       = 3'h4;
	// Clock output selection beyond the sources
	localparam logic [2:0] OUT_SYSCLK    = 3'h5;
	// Frequencies in Hz
	localparam int FAST_RC_LO_HZ   = 32000000;
	localparam int FAST_RC_HI_HZ   = 40000000;
	localparam int SLOW_RC_SLOW_HZ = 640;
	localparam int SLOW_RC_FAST_HZ = 10240;
	localparam int PIN_CLK_MAX_HZ  = 20000000;
	localparam int OUT_CLK_MAX_HZ  = 40000000;
	// Clock rate of this block
	localparam int CLK_HZ          = 20000000;
	// Missing-edge window for the clock monitor, in ns
	localparam int MON_WINDOW_NS   = 3200;
	localparam int MON_CYC         = (MON_WINDOW_NS * (CLK_HZ / 1000000))
		/ 1000;
	localparam int MON_W           = 8;
	localparam logic [MON_W-1:0] MON_LIMIT = MON_W'(MON_CYC);
	// Reset values; bank and peripheral counts
	localparam logic [31:0] SCRATCH_RST = 32'h0000_0000;
	localparam logic [NSRC-1:0] SRC_PD_RST = 5'h02;
	localparam int NBANK = 4;
	localparam int NPERI = 8;

	typedef enum logic [1:0] {
		MODE_RUN,
		MODE_SLEEP,
		MODE_HIBERNATE,
		MODE_SHUTDOWN
	} cpm_mode_t;

	// Software control bits
	typedef struct packed {
		logic [NSRC-1:0]  src_pd;
		logic             fast_rc_hi;
		logic             slow_rc_fast;
		logic [2:0]       sys_sel;
		logic [2:0]       out_sel;
		logic             out_en;
		logic [NPERI-1:0] peri_gate;
		logic [NPERI-1:0] peri_irq_en;
		logic [NBANK-1:0] bank_retain;
		logic             deep_sleep;
		logic             hibernate;
		logic             shutdown;
		logic             mon_nmi_en;
	} cpm_ctrl_t;

	// Power and clock controls driven to the chip
	typedef struct packed {
		logic [NSRC-1:0]  src_en;
		logic             cpu_clk_en;
		logic             flash_lp;
		logic             core_pwr;
		logic             periph_pwr;
		logic [NPERI-1:0] peri_clk_en;
		logic [NBANK-1:0] bank_pwr;
	} cpm_pwr_t;
endpackage

// file: cpm_clock_monitor.sv
module cpm_clock_monitor (
	// Clock and control
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic ce_i,
	input  wire logic arm_i,
	// Monitored clock, already synchronised
	input  wire logic mon_clk_i,
	// Loss flag
	output logic      loss_o
);
	logic                       prev_r;
	logic [cpm_pkg::MON_W-1:0]  cnt_r;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			prev_r <= 1'b0;
		end else if (ce_i) begin
			prev_r <= mon_clk_i;
		end
	end

	// R7: count quiet cycles
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_r  <= '0;
			loss_o <= 1'b0;
		end else if (ce_i) begin
			// Disarm and edges only act while enabled, so ce freezes all
			if (!arm_i || prev_r != mon_clk_i) begin
				cnt_r  <= '0;
				loss_o <= 1'b0;
			end else if (cnt_r == cpm_pkg::MON_LIMIT) begin
				loss_o <= 1'b1;
			end else begin
				cnt_r <= cnt_r + 1'b1;
			end
		end
	end
endmodule

// file: cpm_core_model.sv
module cpm_core_model (
	// Clock and reset
	input  wire logic          clk_i,
	input  wire logic          rst_i,
	// From the power manager
	input  wire logic          cpu_clk_en_i,
	input  wire logic          core_reset_i,
	// Core requests
	output logic               wait_instruction_o,
	output cpm_pkg::cpm_ctrl_t ctrl_o,
	output logic               scratch_we_o,
	output logic [31:0]        scratch_wd_o,
	output int                 restarts_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		wait_instruction_o = 1'b0;
		ctrl_o = '0;
		scratch_we_o = 1'b0;
		scratch_wd_o = 32'h0;
	end
	always @(posedge clk_i) begin
		if (rst_i)
			restarts_o <= 0;
		else if (core_reset_i === 1'b1)
			restarts_o <= restarts_o + 1;
	end
	// trims rewritten here; recalibration not modelled
	task automatic set_ctrl(input cpm_pkg::cpm_ctrl_t c);
		@(negedge clk_i);
		ctrl_o = c;
	endtask
	// a gated core waits up to 50 cycles for its clock, then executes the wait anyway
	task automatic exec_wait();
		for (int k = 0; k < 50 && cpu_clk_en_i !== 1'b1; k++)
			@(negedge clk_i);
		@(negedge clk_i);
		wait_instruction_o = 1'b1;
		@(negedge clk_i);
		wait_instruction_o = 1'b0;
	endtask
	// Data not held after the write, no stale value
	task automatic write_scratch(input logic [31:0] d);
		@(negedge clk_i);
		scratch_we_o = 1'b1;
		scratch_wd_o = d;
		@(negedge clk_i);
		scratch_we_o = 1'b0;
		scratch_wd_o = ~d;
	endtask
endmodule

// file: clock_and_power_mode_manager_tb.sv
module clock_and_power_mode_manager_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic               clk_i, rst_i, wait_i, swe, wt, gt, swp, dbg, nmip;
	logic               frh, srf, cop, coe_n, crst, loss, nmi, hit, pc;
	logic               ce, bo, tog;
	logic [31:0]        swd, scr, e;
	logic [7:0]         irq;
	logic [4:0]         srun, sclk;
	logic [2:0]         ssrc;
	cpm_pkg::cpm_ctrl_t ctrl, c;
	cpm_pkg::cpm_pwr_t  pwr;
	cpm_pkg::cpm_mode_t mode;
	int                 n_mismatch, cmp_count, rs, r0, n;

	cpm_power_manager i_dut (
		.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
		.wait_instruction_i(wait_i), .ctrl_i(ctrl),
		.scratch_we_i(swe), .scratch_wd_i(swd), .peri_irq_i(irq),
		.wake_timer_i(wt), .gpio_toggle_i(gt), .shutdown_wake_pin_i(swp),
		.debug_enable_pin_i(dbg), .nmi_pin_i(nmip), .brownout_i(bo),
		.src_clk_i(sclk), .pwr_o(pwr), .mode_o(mode), .sys_src_o(ssrc),
		.fast_rc_hi_o(frh), .slow_rc_fast_o(srf), .clock_output_pin_o(cop),
		.clock_output_pin_oe_n_o(coe_n), .core_reset_o(crst),
		.clk_loss_o(loss), .nmi_o(nmi), .scratch_o(scr));
	cpm_core_model i_core (
		.clk_i(clk_i), .rst_i(rst_i), .cpu_clk_en_i(pwr.cpu_clk_en),
		.core_reset_i(crst), .wait_instruction_o(wait_i), .ctrl_o(ctrl),
		.scratch_we_o(swe), .scratch_wd_o(swd), .restarts_o(rs));

	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	// sources toggle at 5 MHz, slow enough for the filters; off stops
	always @(negedge clk_i) begin
		tog  <= ~tog;
		sclk <= sclk ^ (srun & (rst_i ? 5'h00 : pwr.src_en) & {5{tog}});
	end
	initial begin
		repeat (20000) @(posedge clk_i);
		n_mismatch++;
		conclude();
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic conclude();
		if (n_mismatch == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic wait_mode(input cpm_pkg::cpm_mode_t m);
		for (int k = 0; k < 40 && mode !== m; k++)
			@(negedge clk_i);
		chk(32'(mode), 32'(m));
		if (mode !== m)
			conclude();
	endtask
	task automatic stay(input cpm_pkg::cpm_mode_t m);
		repeat (12) @(negedge clk_i);
		chk(32'(mode), 32'(m));
	endtask

	initial begin
		n_mismatch = 0;
		cmp_count = 0;
		rst_i = 1'b1;
		{wt, gt, swp, dbg, nmip} = 5'h00;
		irq = 8'h00;
		srun = 5'h1F;
		sclk = 5'h00;
		{ce, bo, tog} = 3'b100;
		repeat (6) @(negedge clk_i);
		rst_i = 1'b0;
		repeat (2) @(negedge clk_i);
		chk(32'(mode), 32'(cpm_pkg::MODE_RUN));
		chk(32'({ssrc, coe_n, loss, nmi, crst}), 32'h08);
		chk(scr, cpm_pkg::SCRATCH_RST);
		// Frozen block must ignore a wait
		ce = 1'b0;
		i_core.exec_wait();
		stay(cpm_pkg::MODE_RUN);
		ce = 1'b1;
		stay(cpm_pkg::MODE_RUN);
		for (int i = 0; i < 2; i++) begin
			c = '0;
			c.src_pd = 5'h18;
			c.fast_rc_hi = i[0];
			c.slow_rc_fast = !i[0];
			c.sys_sel = cpm_pkg::SRC_FAST_XTAL;
			c.out_sel = cpm_pkg::SRC_FAST_XTAL;
			c.out_en = 1'b1;
			c.peri_gate = 8'h0F;
			c.peri_irq_en = 8'h30;
			c.mon_nmi_en = 1'b1;
			i_core.set_ctrl(c);
			repeat (8) @(negedge clk_i);
			chk(32'({frh, srf}), 32'({i[0], !i[0]}));
			chk(32'(pwr), 32'({5'h07, 4'hB, 8'hF0, 4'hF}));
			chk(32'({ssrc, coe_n}), 32'h4);
		end
		n = 0;
		pc = cop;
		repeat (16) begin
			@(negedge clk_i);
			if (cop !== pc)
				n++;
			pc = cop;
		end
		chk(32'(n >= 4), 32'h1);
		for (int i = 0; i < 4; i++) begin
			r0 = rs;
			i_core.exec_wait();
			wait_mode(cpm_pkg::MODE_SLEEP);
			e = 32'({pwr.cpu_clk_en, pwr.flash_lp, pwr.peri_clk_en & 8'h30});
			chk(e, 32'h130);
			// Gated, not enabled: must not wake
			irq = 8'h01;
			stay(cpm_pkg::MODE_SLEEP);
			{wt, nmip, bo} = {i == 0, i == 2, i == 3};
			irq = (i == 1) ? 8'h10 : 8'h00;
			wait_mode(cpm_pkg::MODE_RUN);
			{wt, nmip, bo} = 3'b000;
			irq = 8'h00;
			chk(32'(rs), 32'(r0));
			repeat (4) @(negedge clk_i);
		end
		i_core.write_scratch(32'hA5C3_0F96);
		chk(scr, 32'hA5C3_0F96);
		for (int i = 0; i < 3; i++) begin
			c.deep_sleep = 1'b1;
			c.hibernate = 1'b1;
			c.bank_retain = i[0] ? 4'hA : 4'h5;
			i_core.set_ctrl(c);
			r0 = rs;
			i_core.exec_wait();
			wait_mode(cpm_pkg::MODE_HIBERNATE);
			e = 32'({pwr.src_en, pwr.cpu_clk_en, pwr.core_pwr, pwr.periph_pwr,
				pwr.bank_pwr});
			chk(e, 32'({5'h02, 3'h0, c.bank_retain}));
			irq = 8'h30;
			stay(cpm_pkg::MODE_HIBERNATE);
			irq = 8'h00;
			{wt, gt, dbg} = 3'b100 >> i;
			wait_mode(cpm_pkg::MODE_RUN);
			{wt, gt, dbg} = 3'b000;
			chk(32'(rs), 32'(r0 + 1));
			chk(scr, 32'hA5C3_0F96);
		end
		c.shutdown = 1'b1;
		i_core.set_ctrl(c);
		r0 = rs;
		i_core.exec_wait();
		wait_mode(cpm_pkg::MODE_SHUTDOWN);
		chk(32'({pwr.src_en, pwr.core_pwr}), 32'h0);
		{wt, gt} = 2'b11;
		stay(cpm_pkg::MODE_SHUTDOWN);
		{wt, gt} = 2'b00;
		swp = 1'b1;
		wait_mode(cpm_pkg::MODE_RUN);
		chk(32'(rs), 32'(r0 + 1));
		chk(scr, 32'hA5C3_0F96);
		c.shutdown = 1'b0;
		c.hibernate = 1'b0;
		c.deep_sleep = 1'b0;
		i_core.set_ctrl(c);
		repeat (4) @(negedge clk_i);
		chk(32'({loss, ssrc}), 32'h2);
		srun[2] = 1'b0;
		n = 0;
		hit = 1'b0;
		while (loss !== 1'b1 && n < 120) begin
			@(negedge clk_i);
			hit |= (nmi === 1'b1);
			n++;
		end
		repeat (3) begin
			@(negedge clk_i);
			hit |= (nmi === 1'b1);
		end
		chk(32'(n >= 64 && n < 120), 32'h1);
		chk(32'({loss, ssrc}), 32'h8);
		chk(32'(hit), 32'h1);
		// Fallback must not undo itself
		srun[2] = 1'b1;
		repeat (20) @(negedge clk_i);
		chk(32'(ssrc), 32'(cpm_pkg::SRC_FAST_RC));
		conclude();
	end
endmodule
